// >>> hdl/sdpd_decode.sv
`timescale 1ns/1ps
module sdpd_decode
  import sdpd_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire sdpd_pkg::sdpd_org_type org,
  input  wire logic                 cs_n,
  input  wire logic                 ras_n,
  input  wire logic                 cas_n,
  input  wire logic                 we_n,
  input  wire logic [BANK_W-1:0]    bank_sel,
  input  wire logic [ADDR_W-1:0]    addr,
  sdpd_cmd_if.src                   cmd
);
  import sdpd_pkg::*;

  typedef struct packed {
    logic act_p;
    logic rd_p;
    logic wr_p;
    logic pre_p;
    logic pre_all;
    logic lmr_p;
    logic bst_p;
    logic auto_pre;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic [ADDR_W-1:0] opcode;
  } sdpd_dec_state_type;

  sdpd_dec_state_type st_q, st_d;
  logic [3:0] code;

  always_comb begin
    code = {cs_n, ras_n, cas_n, we_n}; // see RULE1
    st_d = st_q;
    st_d.act_p = 1'b0;
    st_d.rd_p  = 1'b0;
    st_d.wr_p  = 1'b0;
    st_d.pre_p = 1'b0;
    st_d.lmr_p = 1'b0;
    st_d.bst_p = 1'b0;
    if (!cs_n) begin // see RULE15
      case (code)
        SDPD_CMD_ACT: begin
          st_d.act_p = 1'b1;
          st_d.bank  = bank_sel; // see RULE6
          st_d.row   = addr; // see RULE7
        end
        SDPD_CMD_READ, SDPD_CMD_WRITE: begin
          st_d.rd_p     = (code == SDPD_CMD_READ);
          st_d.wr_p     = (code == SDPD_CMD_WRITE);
          st_d.bank     = bank_sel; // see RULE6
          st_d.auto_pre = addr[AP_BIT]; // see RULE9
          case (org) // see RULE8
            SDPD_ORG_X4:  st_d.col = {addr[COL_HI_BIT], addr[9:0]};
            SDPD_ORG_X8:  st_d.col = {1'b0, addr[9:0]};
            SDPD_ORG_X16: st_d.col = {2'b00, addr[8:0]};
            default:      st_d.col = {2'b00, addr[8:0]};
          endcase
        end
        SDPD_CMD_PRE: begin
          st_d.pre_p   = 1'b1;
          st_d.bank    = bank_sel; // see RULE6
          st_d.pre_all = addr[AP_BIT]; // see RULE10
        end
        SDPD_CMD_LMR: begin
          st_d.lmr_p  = 1'b1;
          st_d.opcode = addr; // see RULE11
        end
        SDPD_CMD_BST: st_d.bst_p = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin // see RULE14
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cmd.act_p    = st_q.act_p;
  assign cmd.rd_p     = st_q.rd_p;
  assign cmd.wr_p     = st_q.wr_p;
  assign cmd.pre_p    = st_q.pre_p;
  assign cmd.pre_all  = st_q.pre_all;
  assign cmd.lmr_p    = st_q.lmr_p;
  assign cmd.bst_p    = st_q.bst_p;
  assign cmd.auto_pre = st_q.auto_pre;
  assign cmd.bank     = st_q.bank;
  assign cmd.row      = st_q.row;
  assign cmd.col      = st_q.col;
  assign cmd.opcode   = st_q.opcode;
endmodule

// >>> hdl/sdpd_mask.sv
`timescale 1ns/1ps
module sdpd_mask
  import sdpd_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire sdpd_pkg::sdpd_org_type org,
  input  wire logic                   lower_byte_mask,
  input  wire logic                   upper_byte_mask,
  output logic      [MASK_W-1:0]      lane_mask,
  output logic      [MASK_W-1:0]      lane_mask_dly
);
  import sdpd_pkg::*;

  typedef struct packed {
    logic [MASK_W-1:0] now;
    logic [MASK_LAT-1:0][MASK_W-1:0] pipe;
  } sdpd_mask_state_type;

  sdpd_mask_state_type st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (org == SDPD_ORG_X16) begin
      st_d.now = {upper_byte_mask, lower_byte_mask}; // see RULE4
    end else begin
      st_d.now = {upper_byte_mask, upper_byte_mask}; // see RULE5
    end
    st_d.pipe = {st_q.pipe[MASK_LAT-2:0], st_d.now}; // see RULE3
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Mask sampled this edge, and the one sampled one edge back
  assign lane_mask     = st_q.now; // see RULE13
  assign lane_mask_dly = st_q.pipe[MASK_LAT-1];
endmodule

// >>> hdl/sdpd_top.sv
`timescale 1ns/1ps
module sdpd_top
  import sdpd_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire sdpd_pkg::sdpd_org_type org,
  input  wire logic                   link_clk,
  input  wire logic                   cs_n,
  input  wire logic                   ras_n,
  input  wire logic                   cas_n,
  input  wire logic                   we_n,
  input  wire logic [sdpd_pkg::BANK_W-1:0] bank_sel,
  input  wire logic [sdpd_pkg::ADDR_W-1:0] addr,
  input  wire logic                   lower_byte_mask,
  input  wire logic                   upper_byte_mask,
  input  wire logic [sdpd_pkg::DQ_W-1:0]   dq_in,
  output logic      [sdpd_pkg::DQ_W-1:0]   dq_out,
  output logic      [sdpd_pkg::DQ_W-1:0]   dq_oe,
  output logic      [sdpd_pkg::NUM_BANKS-1:0] bank_open,
  output logic      [sdpd_pkg::ADDR_W-1:0] mode_opcode
);
  import sdpd_pkg::*;

  // Three-stage register chains for all pins
  localparam int PIN_W = 4 + BANK_W + ADDR_W + 2 + DQ_W + 1;
  // Reset to link high and deselected, so no false edge follows reset
  localparam logic [PIN_W-1:0] PIN_RST = {2'b11, {(PIN_W-2){1'b0}}};
  logic [PIN_W-1:0] s1_q, s2_q, s3_q;
  logic link_rise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      s3_q <= PIN_RST;
    end else begin
      s1_q <= {link_clk, cs_n, ras_n, cas_n, we_n, bank_sel, addr,
               lower_byte_mask, upper_byte_mask, dq_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Sample on the synchronised rising edge of the link clock
  assign link_rise = s2_q[PIN_W-1] & ~s3_q[PIN_W-1]; // see RULE14

  logic                 p_cs_n, p_ras_n, p_cas_n, p_we_n;
  logic [BANK_W-1:0]    p_bank;
  logic [ADDR_W-1:0]    p_addr;
  logic                 p_lm, p_um;
  logic [DQ_W-1:0]      p_dq;

  // Outside link edges, present an inhibit so nothing decodes
  assign p_cs_n  = link_rise ? s3_q[PIN_W-2] : 1'b1;
  assign p_ras_n = s3_q[PIN_W-3];
  assign p_cas_n = s3_q[PIN_W-4];
  assign p_we_n  = s3_q[PIN_W-5];
  assign p_bank  = s3_q[PIN_W-6 -: BANK_W];
  assign p_addr  = s3_q[PIN_W-6-BANK_W -: ADDR_W];
  assign p_lm    = s3_q[DQ_W+1];
  assign p_um    = s3_q[DQ_W];
  assign p_dq    = s3_q[DQ_W-1:0];

  sdpd_cmd_if cmd_bus ();
  logic [MASK_W-1:0] lane_mask, lane_mask_dly;
  logic [MASK_W-1:0] mask_hold_q;
  logic              mlm, mum;

  sdpd_decode u_decode (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .org      (org),
    .cs_n     (p_cs_n),
    .ras_n    (p_ras_n),
    .cas_n    (p_cas_n),
    .we_n     (p_we_n),
    .bank_sel (p_bank),
    .addr     (p_addr),
    .cmd      (cmd_bus)
  );

  // Masks only advance on link edges
  assign mlm = link_rise ? p_lm : mask_hold_q[0];
  assign mum = link_rise ? p_um : mask_hold_q[1];

  sdpd_mask u_mask (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .org             (org),
    .lower_byte_mask (mlm),
    .upper_byte_mask (mum),
    .lane_mask       (lane_mask),
    .lane_mask_dly   (lane_mask_dly)
  );

  typedef enum logic [1:0] {
    SDPD_IDLE,
    SDPD_RD,
    SDPD_WR
  } sdpd_burst_type;

  typedef struct packed {
    logic [NUM_BANKS-1:0]             open;
    logic [NUM_BANKS-1:0][ADDR_W-1:0] row;
    logic [ADDR_W-1:0]                opcode;
    sdpd_burst_type                   burst;
    logic [BANK_W-1:0]                bbank;
    logic [COL_W-1:0]                 bcol;
    logic [CNT_W-1:0]                 left;
    logic                             bap;
    logic [RD_LAT-1:0]                rd_v;
    logic [RD_LAT-1:0][DQ_W-1:0]      rd_d;
    logic [DQ_W-1:0]                  dq_o;
    logic [DQ_W-1:0]                  oe;
    logic [MASK_W-1:0]                mhold;
    logic                             wbeat;
    logic [DQ_W-1:0]                  wdat;
  } sdpd_top_state_type;

  sdpd_top_state_type st_q, st_d;
  logic [MEM_ROWS-1:0][MEM_COLS-1:0][DQ_W-1:0] mem_q [NUM_BANKS];
  logic [DQ_W-1:0] bus_mask;
  logic [DQ_W-1:0] rd_word;
  logic            beat;
  logic            adv;
  logic            wr_en;
  logic [BANK_W-1:0] wr_bank;
  logic [COL_W-1:0]  wr_col;

  function automatic logic [DQ_W-1:0] width_mask(sdpd_org_type o);
    case (o) // see RULE12
      SDPD_ORG_X4:  width_mask = 16'h000f;
      SDPD_ORG_X8:  width_mask = 16'h00ff;
      default:      width_mask = 16'hffff;
    endcase
  endfunction

  assign bus_mask = width_mask(org);
  assign mask_hold_q = st_q.mhold;
  assign rd_word = mem_q[st_q.bbank][st_q.row[st_q.bbank][MEM_ROW_W-1:0]]
                        [st_q.bcol[MEM_COL_W-1:0]] & bus_mask;
  assign beat = link_rise;
  // Write beats run one cycle after the link edge, on held data and mask
  assign adv     = (beat && st_q.burst == SDPD_RD) ||
                   (st_q.wbeat && st_q.burst == SDPD_WR);
  assign wr_en   = cmd_bus.wr_p || (st_q.wbeat && st_q.burst == SDPD_WR &&
                   !cmd_bus.rd_p && !cmd_bus.bst_p);
  assign wr_bank = cmd_bus.wr_p ? cmd_bus.bank : st_q.bbank;
  assign wr_col  = cmd_bus.wr_p ? cmd_bus.col : st_q.bcol;

  always_comb begin
    st_d = st_q;
    st_d.wbeat = link_rise;
    if (link_rise) begin
      st_d.mhold = {p_um, p_lm};
      st_d.wdat  = p_dq;
    end
    if (cmd_bus.act_p) begin
      st_d.open[cmd_bus.bank] = 1'b1; // see RULE6
      st_d.row[cmd_bus.bank]  = cmd_bus.row; // see RULE7
    end
    if (cmd_bus.pre_p) begin
      if (cmd_bus.pre_all) begin
        st_d.open = '0; // see RULE10
      end else begin
        st_d.open[cmd_bus.bank] = 1'b0;
      end
    end
    if (cmd_bus.lmr_p) begin
      st_d.opcode = cmd_bus.opcode; // see RULE11
    end
    if (beat) begin
      st_d.rd_v = {st_q.rd_v[RD_LAT-2:0], st_q.burst == SDPD_RD};
      st_d.rd_d = {st_q.rd_d[RD_LAT-2:0], rd_word};
      st_d.dq_o = st_q.rd_d[RD_LAT-1];
      // Lane drivers off when mask seen two edges earlier
      for (int i = 0; i < DQ_W; i++) begin
        st_d.oe[i] = st_q.rd_v[RD_LAT-1] & bus_mask[i] &
                     ~lane_mask_dly[i / 8]; // see RULE3
      end
    end
    if (adv) begin
      st_d.bcol = st_q.bcol + COL_W'(1);
      st_d.left = st_q.left - CNT_W'(1);
      if (st_q.left == CNT_W'(1)) begin
        st_d.burst = SDPD_IDLE;
        if (st_q.bap && !(cmd_bus.act_p && cmd_bus.bank == st_q.bbank)) begin
          st_d.open[st_q.bbank] = 1'b0; // see RULE9
        end
      end
    end
    if (cmd_bus.bst_p) begin
      st_d.burst = SDPD_IDLE;
    end
    // New access; inhibited commands never reach here
    if (cmd_bus.rd_p || cmd_bus.wr_p) begin // see RULE15
      case (cmd_bus.rd_p)
        1'b1:    st_d.burst = SDPD_RD;
        default: st_d.burst = SDPD_WR;
      endcase
      st_d.bbank = cmd_bus.bank;
      st_d.bcol  = cmd_bus.col;
      st_d.bap   = cmd_bus.auto_pre;
      st_d.left  = CNT_W'(BURST_LEN);
      if (cmd_bus.wr_p) begin
        // First write word lands on the command edge itself
        st_d.bcol = cmd_bus.col + COL_W'(1);
        st_d.left = CNT_W'(BURST_LEN - 1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Write path: masked lanes leave memory untouched
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge sys_clk) begin
      if (wr_en && wr_bank == BANK_W'(b)) begin
        for (int i = 0; i < DQ_W; i++) begin
          if (bus_mask[i] && !lane_mask[i / 8]) begin // see RULE2
            mem_q[b][st_q.row[b][MEM_ROW_W-1:0]]
                 [wr_col[MEM_COL_W-1:0]][i] <= st_q.wdat[i];
          end
        end
      end
    end
  end

  assign dq_out      = st_q.dq_o;
  assign dq_oe       = st_q.oe;
  assign bank_open   = st_q.open;
  assign mode_opcode = st_q.opcode;
endmodule

// >>> pkg/sdpd_cmd_if.sv
`timescale 1ns/1ps
interface sdpd_cmd_if;
  import sdpd_pkg::*;
  logic                 act_p;
  logic                 rd_p;
  logic                 wr_p;
  logic                 pre_p;
  logic                 pre_all;
  logic                 lmr_p;
  logic                 bst_p;
  logic                 auto_pre;
  logic [BANK_W-1:0]    bank;
  logic [ADDR_W-1:0]    row;
  logic [COL_W-1:0]     col;
  logic [ADDR_W-1:0]    opcode;
  modport src (output act_p, rd_p, wr_p, pre_p, pre_all, lmr_p, bst_p,
               auto_pre, bank, row, col, opcode);
  modport dst (input act_p, rd_p, wr_p, pre_p, pre_all, lmr_p, bst_p,
               auto_pre, bank, row, col, opcode);
endinterface

// >>> pkg/sdpd_pkg.sv
// Summary of operation
// RULE1: Command decoded from chip select, row strobe, column strobe, write enable.
// RULE2: Write byte with its mask high is discarded; memory byte unchanged.
// RULE3: Read byte with its mask high goes high impedance two clocks later.
// RULE4: Sixteen-bit mode: lower mask governs bits 7..0, upper bits 15..8.
// RULE5: Four and eight-bit modes: lower mask unused, upper mask masks all.
// RULE6: Activate, read, write, precharge go to the two-bit selected bank.
// RULE7: Activate captures all twelve address lines as the row.
// RULE8: Column: x4 bits 9..0 plus 11, x8 bits 9..0, x16 bits 8..0.
// RULE9: Read or write treat address bit 10 as auto-precharge request.
// RULE10: Precharge closes all banks if bit 10 high, else selected bank.
// RULE11: Load mode register takes its operation code from the address lines.
// RULE12: Data bus width sixteen, eight or four bits by organisation.
// RULE13: Generic mask behaviour applies to both lower and upper masks alike.
// RULE14: All command, address, mask and data inputs sampled on rising clock.
// RULE15: Chip select high ignores commands; bursts and masking continue.
package sdpd_pkg;
  localparam int ADDR_W     = 12;
  localparam int BANK_W     = 2;
  localparam int NUM_BANKS  = 4;
  localparam int DQ_W       = 16;
  localparam int COL_W      = 11;
  localparam int MASK_W     = 2;
  localparam int AP_BIT     = 10;
  localparam int COL_HI_BIT = 11;
  localparam int RD_LAT     = 2;
  localparam int MASK_LAT   = 2;
  localparam int BURST_LEN  = 4;
  localparam int CNT_W      = 3;
  localparam int MEM_ROWS   = 16;
  localparam int MEM_ROW_W  = 4;
  localparam int MEM_COLS   = 16;
  localparam int MEM_COL_W  = 4;

  typedef enum logic [1:0] {
    SDPD_ORG_X4,
    SDPD_ORG_X8,
    SDPD_ORG_X16
  } sdpd_org_type;

  // Active-low pins: {cs, ras, cas, we}
  typedef enum logic [3:0] {
    SDPD_CMD_INHIBIT = 4'h8,
    SDPD_CMD_LMR     = 4'h0,
    SDPD_CMD_REF     = 4'h1,
    SDPD_CMD_PRE     = 4'h2,
    SDPD_CMD_ACT     = 4'h3,
    SDPD_CMD_WRITE   = 4'h4,
    SDPD_CMD_READ    = 4'h5,
    SDPD_CMD_BST     = 4'h6,
    SDPD_CMD_NOP     = 4'h7
  } sdpd_cmd_type;
endpackage

// >>> tb/sdpd_ctl_model.sv
`timescale 1ns/1ps
module sdpd_ctl_model
  import sdpd_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      link_clk,
  output logic                           cs_n,
  output logic                           ras_n,
  output logic                           cas_n,
  output logic                           we_n,
  output logic [sdpd_pkg::BANK_W-1:0]    bank_sel,
  output logic [sdpd_pkg::ADDR_W-1:0]    addr,
  output logic                           lower_byte_mask,
  output logic                           upper_byte_mask,
  output logic [sdpd_pkg::DQ_W-1:0]      dq_in
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = SDPD_CMD_NOP;
    bank_sel = '0;
    addr = '0;
    lower_byte_mask = 1'b0;
    upper_byte_mask = 1'b0;
    dq_in = '0;
  end

  // Pins move half a link period away from the sampling edge
  task automatic issue(input logic [3:0] c, input logic [1:0] ba,
                       input logic [11:0] a, input logic lm,
                       input logic um, input logic wd,
                       input logic [15:0] d);
    @(negedge link_clk);
    @(posedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bank_sel <= ba;
    addr <= a;
    lower_byte_mask <= lm;
    upper_byte_mask <= um;
    // Released data lines do not keep the last value
    dq_in <= wd ? d : ~dq_in;
  endtask
endmodule

// >>> tb/sdpd_top_monitor.sv
`timescale 1ns/1ps
module sdpd_top_monitor
  import sdpd_pkg::*;
(
  input wire logic                         sys_clk,
  input wire logic                         rst_n,
  input wire sdpd_pkg::sdpd_org_type       org,
  input wire logic                         link_clk,
  input wire logic                         cs_n,
  input wire logic                         ras_n,
  input wire logic                         cas_n,
  input wire logic                         we_n,
  input wire logic [sdpd_pkg::BANK_W-1:0]  bank_sel,
  input wire logic [sdpd_pkg::ADDR_W-1:0]  addr,
  input wire logic                         lower_byte_mask,
  input wire logic                         upper_byte_mask,
  input wire logic [sdpd_pkg::DQ_W-1:0]    dq_in,
  input wire logic [sdpd_pkg::DQ_W-1:0]    dq_out,
  input wire logic [sdpd_pkg::DQ_W-1:0]    dq_oe,
  input wire logic [sdpd_pkg::NUM_BANKS-1:0] bank_open,
  input wire logic [sdpd_pkg::ADDR_W-1:0]  mode_opcode
);
  logic        lk_q;
  logic        cap_p;
  logic        um_l;
  logic        lm_l;
  logic [3:0]  cmd_l;
  logic [1:0]  ba_l;
  logic [11:0] a_l;

  // Pins as they stood at the last link rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_q  <= 1'b1;
      cap_p <= 1'b0;
      cmd_l <= SDPD_CMD_NOP;
      ba_l  <= '0;
      a_l   <= '0;
      um_l  <= 1'b0;
      lm_l  <= 1'b0;
    end else begin
      lk_q  <= link_clk;
      cap_p <= link_clk & ~lk_q;
      if (link_clk & ~lk_q) begin
        cmd_l <= {cs_n, ras_n, cas_n, we_n};
        ba_l  <= bank_sel;
        a_l   <= addr;
        um_l  <= upper_byte_mask;
        lm_l  <= lower_byte_mask;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_two_later;
    ##[0:8] cap_p ##[1:9] cap_p;
  endsequence

  a_x8_bus_width: assert property (
    org == SDPD_ORG_X8 |-> dq_oe inside {16'h0000, 16'h00ff})
    else $error("x8 drive enables wrong");
  a_x4_bus_width: assert property (
    org == SDPD_ORG_X4 |-> dq_oe inside {16'h0000, 16'h000f})
    else $error("x4 drive enables wrong");
  a_x16_lane_groups: assert property (
    org == SDPD_ORG_X16 |-> dq_oe[7:0] inside {8'h00, 8'hff}
      && dq_oe[15:8] inside {8'h00, 8'hff})
    else $error("x16 lanes split");
  a_act_opens_bank: assert property (
    cap_p && cmd_l == SDPD_CMD_ACT |-> ##[1:7] bank_open[ba_l])
    else $error("activate did not open bank");
  a_open_needs_act: assert property (
    (bank_open & ~$past(bank_open)) != 4'h0 |-> cmd_l == SDPD_CMD_ACT
      && bank_open == ($past(bank_open) | (4'h1 << ba_l)))
    else $error("bank opened without activate");
  a_pre_all_closes: assert property (
    cap_p && cmd_l == SDPD_CMD_PRE && a_l[10] |-> ##[1:7] bank_open == 4'h0)
    else $error("precharge all left bank open");
  a_pre_one_closes: assert property (
    cap_p && cmd_l == SDPD_CMD_PRE && !a_l[10] |-> ##[1:7] !bank_open[ba_l])
    else $error("precharge left bank open");
  a_lmr_opcode: assert property (
    cap_p && cmd_l == SDPD_CMD_LMR |-> ##[1:7] mode_opcode == a_l)
    else $error("mode opcode not taken");
  a_upper_mask_hiz: assert property (
    (cap_p && um_l) ##1 s_two_later |-> ##[1:7]
      (org == SDPD_ORG_X16 ? dq_oe[15:8] == 8'h00 : dq_oe == 16'h0000))
    else $error("upper mask left drivers on");
  a_lower_mask_hiz: assert property (
    (cap_p && lm_l && org == SDPD_ORG_X16) ##1 s_two_later
      |-> ##[1:7] dq_oe[7:0] == 8'h00)
    else $error("lower mask left drivers on");
endmodule

bind sdpd_top sdpd_top_monitor i_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .org(org), .link_clk(link_clk),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .bank_sel(bank_sel), .addr(addr), .lower_byte_mask(lower_byte_mask),
  .upper_byte_mask(upper_byte_mask), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe(dq_oe), .bank_open(bank_open), .mode_opcode(mode_opcode));

// >>> tb/test_sdpd_pin_command_mask_decode.sv
`timescale 1ns/1ps
module test_sdpd_pin_command_mask_decode;
  import sdpd_pkg::*;
  logic         sys_clk = 1'b0;
  logic         link_clk = 1'b0;
  logic         rst_n = 1'b0;
  sdpd_org_type org = SDPD_ORG_X16;
  logic         cs_n, ras_n, cas_n, we_n, lbm, ubm;
  logic [1:0]   bank_sel;
  logic [11:0]  addr;
  logic [15:0]  dq_in, dq_out, dq_oe;
  logic [3:0]   bank_open;
  logic [11:0]  mode_opcode;
  logic [15:0]  wdat[4], rdat[4], roe[4];
  int           error_cnt = 0;
  int           samples_checked = 0;

  always #50 sys_clk = ~sys_clk;
  initial begin
    #37;
    forever #400 link_clk = ~link_clk;
  end

  sdpd_ctl_model i_ctl (.sys_clk(sys_clk), .link_clk(link_clk),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_sel(bank_sel), .addr(addr), .lower_byte_mask(lbm),
    .upper_byte_mask(ubm), .dq_in(dq_in));
  sdpd_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .org(org),
    .link_clk(link_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_sel(bank_sel), .addr(addr), .lower_byte_mask(lbm),
    .upper_byte_mask(ubm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .bank_open(bank_open), .mode_opcode(mode_opcode));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset(input sdpd_org_type o);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    org <= o;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] ba,
                     input logic [11:0] a);
    i_ctl.issue(c, ba, a, 1'b0, 1'b0, 1'b0, 16'h0);
  endtask

  task automatic nop(input int n);
    repeat (n) cmd(SDPD_CMD_NOP, 2'h0, 12'h0);
  endtask

  task automatic t_mode_load();
    cmd(SDPD_CMD_LMR, 2'h0, 12'h2a5);
    cmd(SDPD_CMD_INHIBIT, 2'h0, 12'h5a3);
    nop(2);
    check({4'h0, mode_opcode}, 16'h02a5);
  endtask

  task automatic t_banks();
    logic [3:0] q[5] = '{SDPD_CMD_REF, SDPD_CMD_BST, SDPD_CMD_NOP,
                         SDPD_CMD_INHIBIT, 4'hb};
    for (int b = 0; b < 4; b++) cmd(SDPD_CMD_ACT, 2'(b), 12'hff0);
    nop(2);
    check({12'h0, bank_open}, 16'h000f);
    cmd(SDPD_CMD_PRE, 2'h2, 12'h000);
    cmd(4'ha, 2'h0, 12'h400);
    nop(2);
    check({12'h0, bank_open}, 16'h000b);
    cmd(SDPD_CMD_PRE, 2'h0, 12'h400);
    foreach (q[i]) cmd(q[i], 2'h3, 12'h0);
    nop(2);
    check({12'h0, bank_open}, 16'h0000);
  endtask

  task automatic xfer(input logic rd, input logic [11:0] a,
                      input logic [3:0] lm, input logic [3:0] um);
    int t;
    fork
      for (int k = 0; k < 6; k++)
        i_ctl.issue(k == 0 ? (rd ? SDPD_CMD_READ : SDPD_CMD_WRITE) :
          SDPD_CMD_INHIBIT, 2'h1, a, k < 4 && lm[k], k < 4 && um[k],
          !rd && k < 4, wdat[k % 4]);
      if (rd) begin
        t = 0;
        while (dq_oe === 16'h0 && t < 80) begin
          @(posedge sys_clk);
          #1;
          t++;
        end
        repeat (2) @(posedge sys_clk);
        for (int j = 0; j < 4; j++) begin
          #1;
          rdat[j] = dq_out;
          roe[j] = dq_oe;
          repeat (8) @(posedge sys_clk);
        end
      end
    join
  endtask

  task automatic mask_run(input sdpd_org_type o);
    logic [15:0] wm, ev, eo, a;
    logic        mlo;
    do_reset(o);
    wm = o == SDPD_ORG_X16 ? 16'hffff : o == SDPD_ORG_X8 ? 16'h00ff : 16'h000f;
    cmd(SDPD_CMD_ACT, 2'h1, 12'h003);
    for (int j = 0; j < 4; j++) wdat[j] = 16'h1234 + 16'h1111 * 16'(j);
    xfer(1'b0, 12'h004, 4'h0, 4'h0);
    for (int j = 0; j < 4; j++) wdat[j] = ~wdat[j];
    xfer(1'b0, 12'h004, 4'h3, 4'h4);
    xfer(1'b1, 12'h404, 4'h4, 4'h8);
    for (int j = 0; j < 4; j++) begin
      a = ~wdat[j];
      mlo = o == SDPD_ORG_X16 ? (j < 2) : (j == 2);
      ev = {j == 2 ? a[15:8] : wdat[j][15:8], mlo ? a[7:0] : wdat[j][7:0]};
      eo = (j == 0 && o == SDPD_ORG_X16) ? 16'hff00 :
           j != 1 ? wm : (o == SDPD_ORG_X16 ? 16'h00ff : 16'h0000);
      check(roe[j], eo);
      check(rdat[j] & eo, ev & eo);
    end
    check({12'h0, bank_open}, 16'h0000);
  endtask

  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    do_reset(SDPD_ORG_X16);
    t_mode_load();
    t_banks();
    mask_run(SDPD_ORG_X16);
    mask_run(SDPD_ORG_X8);
    mask_run(SDPD_ORG_X4);
    tally_and_finish();
  end
endmodule
